// [verilog/pwr_seq_pkg.sv]
package pwr_seq_pkg;

   // ----------------------------------------
   // Clock
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 50_000;

   // ----------------------------------------
   // Timing in their own units
   // ----------------------------------------
   localparam int unsigned POWER_UP_WAIT_US = 150;
   localparam int unsigned RESET_PULSE_MIN_NS = 200;
   localparam int unsigned RESET_RELEASE_TO_SELECT_NS = 200;
   localparam int unsigned RESET_ASSERT_TO_SELECT_NS = 400;
   localparam int unsigned SUPPLY_LOW_DURATION_18_US = 30;
   localparam int unsigned SUPPLY_LOW_DURATION_30_US = 50;

   // ----------------------------------------
   // Cycle counts
   // ----------------------------------------
   function automatic int unsigned ceil_cycles(input int unsigned ps);
      int unsigned c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int unsigned floor_cycles(input int unsigned ps);
      int unsigned c;
      c = ps / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   // Device side: longest init time, rounded down
   localparam int unsigned POWER_UP_WAIT_CYC =
      floor_cycles(POWER_UP_WAIT_US * 1000 * 1000);
   // Controller side: least times, rounded up
   localparam int unsigned HOST_POWER_UP_WAIT_CYC =
      ceil_cycles(POWER_UP_WAIT_US * 1000 * 1000);
   localparam int unsigned RESET_PULSE_MIN_CYC =
      ceil_cycles(RESET_PULSE_MIN_NS * 1000);
   localparam int unsigned RESET_RELEASE_TO_SELECT_CYC =
      ceil_cycles(RESET_RELEASE_TO_SELECT_NS * 1000);
   localparam int unsigned RESET_ASSERT_TO_SELECT_CYC =
      ceil_cycles(RESET_ASSERT_TO_SELECT_NS * 1000);

   localparam int unsigned CNT_W = 16;

   // ----------------------------------------
   // Configuration and refresh defaults
   // ----------------------------------------
   localparam int unsigned CFG_W = 16;
   localparam int unsigned ROW_W = 13;
   localparam logic [15:0] CFG0_DEFAULT = 16'h8F1F;
   localparam logic [15:0] CFG1_DEFAULT = 16'h0002;
   localparam logic [12:0] ROW_DEFAULT = 13'h0000;

   // ----------------------------------------
   // Device states
   // ----------------------------------------
   typedef enum logic [3:0] {
      DEV_RESET = 4'b0001,
      DEV_INIT = 4'b0010,
      DEV_STANDBY = 4'b0100,
      DEV_DEEP_PD = 4'b1000
   } dev_state_t;

   // ----------------------------------------
   // Controller states
   // ----------------------------------------
   typedef enum logic [4:0] {
      HOST_PULSE = 5'b00001,
      HOST_RELEASE = 5'b00010,
      HOST_INIT_WAIT = 5'b00100,
      HOST_READY = 5'b01000,
      HOST_BUSY = 5'b10000
   } host_state_t;

endpackage

// [verilog/pwr_seq_if.sv]
`timescale 1ns/1ps
interface pwr_seq_if;
   logic reset_n;
   logic cs_n;

   modport ctrl (
      output reset_n,
      output cs_n
   );

   modport mem (
      input reset_n,
      input cs_n
   );
endinterface

// [verilog/psram_reset_dev.sv]
`timescale 1ns/1ps
// Behaviour
// - After stable power and reset high, initialise
// - Controller keeps select high during power-up
// - Controller starts no transaction during init
// - Reset low delays the start of init
// - Reset low returns device to standby
// - Reset pulse at least 200 ns, no traffic
// - Reset restores configuration registers to default
// - Self-refresh halts while reset low
// - Reset forces exit from deep power down
// - Reset sets refresh row counter to default
// - Controller treats array as lost after reset
// - Release to select at least 200 ns
// - Reset assert to select at least 400 ns
// - Short supply dip needs a hardware reset (model: power_good_i low alone restarts init, no reset pulse)
module psram_reset_dev #(
   parameter int unsigned INIT_CYC = pwr_seq_pkg::POWER_UP_WAIT_CYC,
   parameter int unsigned REFRESH_DIV = 16
) (
   // Clock and supply
   input wire logic clk_i,
   input wire logic power_good_i,
   // Link
   pwr_seq_if.mem link,
   // Power-down command from the access logic
   input wire logic deep_pd_req_i,
   // Status
   output logic ready_o,
   output logic init_busy_o,
   output logic deep_pd_o,
   output logic refresh_on_o,
   output logic [15:0] cfg0_o,
   output logic [15:0] cfg1_o,
   output logic [12:0] refresh_row_o,
   output logic access_err_o
);

   initial begin
      if (INIT_CYC < 1 || INIT_CYC >= (1 << pwr_seq_pkg::CNT_W))
         $error("INIT_CYC out of range");
      if (REFRESH_DIV < 1 || REFRESH_DIV > 256)
         $error("REFRESH_DIV out of range");
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   pwr_seq_pkg::dev_state_t state_q, state_d;
   logic [pwr_seq_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [7:0] div_q, div_d;
   logic [15:0] cfg0_q, cfg1_q;
   logic [12:0] row_q;
   logic err_q;

   wire held = !power_good_i || !link.reset_n;
   wire init_done = (cnt_q == pwr_seq_pkg::CNT_W'(INIT_CYC - 1));
   wire refresh_tick = (div_q == 8'(REFRESH_DIV - 1));
   // Self-refresh runs whenever power is good and reset is high, also in deep power down
   wire refresh_run = !held;
   wire selected = !link.cs_n;

   // ----------------------------------------
   // State machine
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         pwr_seq_pkg::DEV_RESET: begin
            cnt_d = '0;
            state_d = pwr_seq_pkg::DEV_INIT;
         end
         pwr_seq_pkg::DEV_INIT: begin
            cnt_d = cnt_q + 1'b1;
            if (init_done) begin
               state_d = pwr_seq_pkg::DEV_STANDBY;
            end
         end
         pwr_seq_pkg::DEV_STANDBY: begin
            if (deep_pd_req_i) begin
               state_d = pwr_seq_pkg::DEV_DEEP_PD;
            end
         end
         pwr_seq_pkg::DEV_DEEP_PD: begin
            state_d = pwr_seq_pkg::DEV_DEEP_PD;
         end
         default: begin
            state_d = pwr_seq_pkg::DEV_RESET;
         end
      endcase
      if (held) begin
         state_d = pwr_seq_pkg::DEV_RESET;
         cnt_d = '0;
      end
   end

   assign div_d = refresh_tick ? 8'h00 : div_q + 8'h01;

   always_ff @(posedge clk_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
   end

   // ----------------------------------------
   // Configuration and refresh
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (held) begin
         cfg0_q <= pwr_seq_pkg::CFG0_DEFAULT;
         cfg1_q <= pwr_seq_pkg::CFG1_DEFAULT;
         row_q <= pwr_seq_pkg::ROW_DEFAULT;
         div_q <= 8'h00;
      end else begin
         div_q <= div_d;
         if (refresh_run && refresh_tick) begin
            row_q <= row_q + 13'h0001;
         end
      end
   end

   // Selection while not ready is recorded until the next reset
   always_ff @(posedge clk_i) begin
      if (held) begin
         err_q <= 1'b0;
      end else if (selected &&
                   state_q != pwr_seq_pkg::DEV_STANDBY) begin
         err_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign ready_o = (state_q == pwr_seq_pkg::DEV_STANDBY);
   assign init_busy_o = (state_q == pwr_seq_pkg::DEV_INIT);
   assign deep_pd_o = (state_q == pwr_seq_pkg::DEV_DEEP_PD);
   assign refresh_on_o = refresh_run;
   assign cfg0_o = cfg0_q;
   assign cfg1_o = cfg1_q;
   assign refresh_row_o = row_q;
   assign access_err_o = err_q;

endmodule

// [verilog/psram_reset_ctrl.sv]
`timescale 1ns/1ps
module psram_reset_ctrl #(
   parameter int unsigned INIT_CYC = pwr_seq_pkg::HOST_POWER_UP_WAIT_CYC,
   parameter int unsigned PULSE_CYC = pwr_seq_pkg::RESET_PULSE_MIN_CYC,
   parameter int unsigned RELEASE_CYC =
      pwr_seq_pkg::RESET_RELEASE_TO_SELECT_CYC,
   parameter int unsigned ASSERT_CYC =
      pwr_seq_pkg::RESET_ASSERT_TO_SELECT_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Link
   pwr_seq_if.ctrl link,
   // User side
   input wire logic hw_reset_req_i,
   input wire logic access_req_i,
   input wire logic access_end_i,
   output logic ready_o,
   output logic access_gnt_o,
   output logic data_lost_o
);

   initial begin
      if (PULSE_CYC < 1 || RELEASE_CYC < 1 || INIT_CYC < 1 ||
          INIT_CYC >= (1 << pwr_seq_pkg::CNT_W) ||
          ASSERT_CYC < PULSE_CYC + RELEASE_CYC)
         $error("Controller timing parameters invalid");
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   pwr_seq_pkg::host_state_t state_q, state_d;
   logic [pwr_seq_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic lost_q;

   // Hold rounded up so the pulse plus release window also covers 400 ns
   localparam int unsigned HOLD_CYC =
      (ASSERT_CYC > PULSE_CYC + RELEASE_CYC) ?
      ASSERT_CYC - RELEASE_CYC : PULSE_CYC;
   localparam int unsigned WAIT_CYC =
      (INIT_CYC > RELEASE_CYC) ? INIT_CYC : RELEASE_CYC;
   wire hold_done = (cnt_q >= pwr_seq_pkg::CNT_W'(HOLD_CYC - 1));
   wire wait_done = (cnt_q >= pwr_seq_pkg::CNT_W'(WAIT_CYC - 1));

   // ----------------------------------------
   // State machine
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + 1'b1;
      unique case (state_q)
         pwr_seq_pkg::HOST_PULSE: begin
            if (hold_done) begin
               state_d = pwr_seq_pkg::HOST_INIT_WAIT;
               cnt_d = '0;
            end
         end
         pwr_seq_pkg::HOST_INIT_WAIT: begin
            if (wait_done) begin
               state_d = pwr_seq_pkg::HOST_READY;
            end
         end
         pwr_seq_pkg::HOST_READY: begin
            if (hw_reset_req_i) begin
               state_d = pwr_seq_pkg::HOST_PULSE;
               cnt_d = '0;
            end else if (access_req_i) begin
               state_d = pwr_seq_pkg::HOST_BUSY;
            end
         end
         pwr_seq_pkg::HOST_BUSY: begin
            if (access_end_i) begin
               state_d = pwr_seq_pkg::HOST_READY;
            end
         end
         default: begin
            state_d = pwr_seq_pkg::HOST_PULSE;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_q <= pwr_seq_pkg::HOST_PULSE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Array content flagged lost after each hardware reset
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         lost_q <= 1'b1;
      end else if (state_q == pwr_seq_pkg::HOST_PULSE) begin
         lost_q <= 1'b1;
      end else if (access_req_i &&
                   state_q == pwr_seq_pkg::HOST_READY) begin
         lost_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign link.reset_n = (state_q != pwr_seq_pkg::HOST_PULSE);
   assign link.cs_n = (state_q != pwr_seq_pkg::HOST_BUSY);
   assign ready_o = (state_q == pwr_seq_pkg::HOST_READY);
   assign access_gnt_o = (state_q == pwr_seq_pkg::HOST_BUSY);
   assign data_lost_o = lost_q;

endmodule

// [tb/psram_seq_properties.sv]
`timescale 1ns/1ps
module psram_seq_properties #(
   parameter int unsigned INIT_CYC = 10
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Link
   input wire logic reset_n,
   input wire logic cs_n
);
   // ----------------------------------------
   // Cycles since reset release
   // ----------------------------------------
   logic [15:0] up_cnt_q;
   always_ff @(posedge clk_i) begin
      if (!rstn_i || !reset_n) begin
         up_cnt_q <= 16'h0000;
      end else if (up_cnt_q != 16'hffff) begin
         up_cnt_q <= up_cnt_q + 16'h0001;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   chk_pulse_len: assert property (
      $fell(reset_n) |=> !reset_n[*3] ##1 reset_n)
      else $error("reset pulse length wrong");
   chk_no_sel_reset: assert property (!reset_n |-> cs_n)
      else $error("select during reset");
   chk_release_gap: assert property ($rose(reset_n) |-> cs_n[*4])
      else $error("select too soon after release");
   chk_assert_gap: assert property ($fell(reset_n) |-> cs_n[*8])
      else $error("select too soon after reset assert");
   chk_init_first: assert property (
      $fell(cs_n) |-> reset_n && (up_cnt_q >= INIT_CYC))
      else $error("select before init wait ended");
   chk_init_hold: assert property (
      reset_n && (up_cnt_q < INIT_CYC) |-> cs_n)
      else $error("select inside init wait");
   chk_powerup_idle: assert property (
      $rose(rstn_i) |-> !reset_n && cs_n)
      else $error("link not idle at power up");
   chk_sel_cause: assert property (
      $fell(cs_n) |-> $past(reset_n, 4))
      else $error("select without settled release");
endmodule

// [tb/psram_power_up_and_reset_sequencing_tb_top.sv]
`timescale 1ns/1ps
module psram_power_up_and_reset_sequencing_tb_top;
   localparam int unsigned INIT = 10;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic pgood = 1'b0;
   logic dpd_req = 1'b0;
   logic hw_req = 1'b0;
   logic acc_req = 1'b0;
   logic acc_end = 1'b0;
   logic c_ready, lost, d_ready, busy, deep_power_down, refr, err, f_err, gnt;
   logic [15:0] cfg0, cfg1;
   logic [12:0] row;
   int unsigned errors = 0;
   int unsigned num_checks = 0;
   int unsigned rel_cyc = 0;
   int unsigned exp_q[$];
   pwr_seq_if lnk();
   pwr_seq_if flt();
   always #25 clk_i = ~clk_i;
   // ----------------------------------------
   // Design under test
   // ----------------------------------------
   psram_reset_ctrl #(.INIT_CYC(INIT)) u_psram_reset_ctrl (
      .clk_i(clk_i), .rstn_i(rstn_i), .link(lnk.ctrl),
      .hw_reset_req_i(hw_req), .access_req_i(acc_req),
      .access_end_i(acc_end), .ready_o(c_ready), .access_gnt_o(gnt),
      .data_lost_o(lost));
   psram_reset_dev #(.INIT_CYC(INIT)) u_psram_reset_dev (
      .clk_i(clk_i), .power_good_i(pgood), .link(lnk.mem),
      .deep_pd_req_i(dpd_req), .ready_o(d_ready), .init_busy_o(busy),
      .deep_pd_o(deep_power_down), .refresh_on_o(refr), .cfg0_o(cfg0),
      .cfg1_o(cfg1), .refresh_row_o(row), .access_err_o(err));
   psram_reset_dev #(.INIT_CYC(INIT)) u_psram_reset_dev_2 (
      .clk_i(clk_i), .power_good_i(pgood), .link(flt.mem),
      .deep_pd_req_i(1'b0), .ready_o(), .init_busy_o(), .deep_pd_o(),
      .refresh_on_o(), .cfg0_o(), .cfg1_o(), .refresh_row_o(),
      .access_err_o(f_err));
   psram_seq_properties #(.INIT_CYC(INIT)) u_props (
      .clk_i(clk_i), .rstn_i(rstn_i), .reset_n(lnk.reset_n),
      .cs_n(lnk.cs_n));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 100 && c_ready !== 1'b1; i++) @(negedge clk_i);
      chk("ctrl_ready", c_ready, 1);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Ready monitor
   // ----------------------------------------
   always @(posedge clk_i) begin
      rel_cyc <= (!lnk.reset_n || !pgood) ? 0 : rel_cyc + 1;
   end
   initial forever begin
      @(posedge d_ready);
      #1;
      chk("ready_lat", rel_cyc, exp_q.size() ? exp_q.pop_front() : 0);
      chk("cfg0", cfg0, pwr_seq_pkg::CFG0_DEFAULT);
      chk("cfg1", cfg1, pwr_seq_pkg::CFG1_DEFAULT);
      chk("deep_pd", deep_power_down, 0);
   end
   initial begin
      #(50 * 4000);
      errors++;
      tally_and_finish();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'h13f6));
      flt.reset_n = 1'b0;
      flt.cs_n = 1'b1;
      cyc(3);
      pgood = 1'b1;
      cyc(17);
      chk("init_busy", busy, 0);
      chk("refresh_on", refr, 0);
      exp_q.push_back(INIT + 1);
      rstn_i = 1'b1;
      wait_ready();
      chk("data_lost", lost, 1);
      chk("refresh_on", refr, 1);
      chk("init_busy", busy, 1);
      for (int i = 0; i < 4; i++) begin
         acc_req = 1'b1;
         cyc(1);
         acc_req = 1'b0;
         chk("cs_n", lnk.cs_n, 0);
         chk("access_gnt", gnt, 1);
         chk("data_lost", lost, 0);
         cyc($urandom_range(1, 6));
         acc_end = 1'b1;
         cyc(1);
         acc_end = 1'b0;
         chk("access_err", err, 0);
         chk("access_gnt", gnt, 0);
      end
      dpd_req = 1'b1;
      cyc(2);
      dpd_req = 1'b0;
      chk("deep_pd", deep_power_down, 1);
      exp_q.push_back(INIT + 1);
      hw_req = 1'b1;
      cyc(1);
      hw_req = 1'b0;
      cyc(2);
      chk("deep_pd", deep_power_down, 0);
      chk("dev_ready", d_ready, 0);
      chk("row", row, pwr_seq_pkg::ROW_DEFAULT);
      chk("refresh_on", refr, 0);
      wait_ready();
      chk("data_lost", lost, 1);
      cyc(40);
      chk("row_moves", row != pwr_seq_pkg::ROW_DEFAULT, 1);
      flt.reset_n = 1'b1;
      cyc(3);
      flt.cs_n = 1'b0;
      cyc(1);
      flt.cs_n = 1'b1;
      cyc(1);
      chk("fault_err", f_err, 1);
      flt.reset_n = 1'b0;
      cyc(2);
      chk("fault_err", f_err, 0);
      exp_q.push_back(INIT + 1);
      pgood = 1'b0;
      cyc(1);
      pgood = 1'b1;
      cyc(INIT + 4);
      chk("dev_ready", d_ready, 1);
      chk("pending", exp_q.size(), 0);
      tally_and_finish();
   end
endmodule
